//--- hw/epc_host.sv
// Host controller that drives the protected serial EEPROM over its serial pins
`timescale 1ns/1ps
`include "epc_consts.svh"

// Operation
// R1 - Guard read returns the boundary after a zero dummy bit on serial_out.
// R2 - Guard read: start, opcode 10, address don't care, protect_select high.
// R3 - Device arms the guard only while writes are unlocked.
// R4 - Guard arm: start, opcode 00, address 11xxxxxx, both select pins high.
// R5 - Guard erase, set and freeze need guard arm as the previous instruction.
// R6 - Guard erase: opcode 11, address all ones, clears the boundary.
// R7 - Select pins high only while loading; ignored afterwards.
// R8 - Cleared state differs from an all-ones boundary; top word stays writable.
// R9 - An all-ones boundary from guard set refuses fill-all.
// R10 - Guard set: opcode 01 with address, protects words at and above it.
// R11 - Host must erase the guard before setting a new boundary.
// R12 - Guard freeze: opcode 00, address zero, locks the guard forever.
// R13 - Array read: opcode 10, address, protect_select low, returns data.
// R14 - Write unlock: opcode 00, address 11xxxxxx, program_allow high.
// R15 - Word write: opcode 01, address, sixteen data bits, program_allow high.
// R16 - Fill-all: opcode 00, address 01xxxxxx, data, program_allow high.
// R17 - Write lock: opcode 00, address 00xxxxxx, disables programming.
// R18 - Top address bit is ignored by the device.
// R19 - With protect_select low, instructions act on the array.
// R20 - Device samples serial_in on the rising serial_clock edge.
// R21 - Programming starts at chip_select fall; serial_out low busy, high done.
// R22 - Device powers up write-locked.
// R23 - Unarmed guard changes are ignored; any other instruction disarms.
// R24 - After freeze, guard changes have no effect, persistently.
// R25 - Dropping chip_select abandons a partial instruction.
module epc_host import epc_pkg::*; #(
  parameter int unsigned WP_CYCLES = `EPC_WP_CYC
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // User command port
  input wire logic cmd_valid,
  output logic cmd_ready,
  input wire epc_cmd_t cmd_op,
  input wire logic [7:0] cmd_addr,
  input wire logic [15:0] cmd_data,
  // User response port
  output logic rsp_valid,
  output logic [15:0] rsp_data,
  output logic rsp_err,
  // Device pins
  output logic chip_select,
  output logic serial_clock,
  output logic serial_in,
  output logic protect_select,
  output logic program_allow,
  input wire logic serial_out
);

  localparam logic [3:0] SK_HALF_M1 = 4'(`EPC_SK_HALF_CYC - 1);
  localparam logic [20:0] CS_LOW_M1 = 21'(`EPC_CS_LOW_CYC - 1);
  localparam logic [20:0] SV_CYC = 21'(`EPC_SV_CYC);
  localparam logic [20:0] WP_M1 = 21'(WP_CYCLES - 1);

  epc_host_state_t s_reg;
  epc_host_state_t s_next;
  logic so_sync;
  logic tick;

  // ----------------------------------------------------------------
  // Pin input
  // ----------------------------------------------------------------
  epc_in_sync #(.WIDTH(1)) u_so_sync (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .async_in(serial_out),
    .sync_out(so_sync)
  );

  // ----------------------------------------------------------------
  // Frame builder
  // ----------------------------------------------------------------
  function automatic epc_host_state_t launch(epc_host_state_t s, epc_cmd_t op);
    epc_host_state_t r;
    logic [1:0] opc;
    logic [7:0] a;
    logic wide;
    r = s;
    opc = `EPC_OP_00;
    a = `EPC_ADDR_LOCK;
    wide = 1'b0;
    r.ps = 1'b0;
    r.pa = 1'b0;
    r.poll = 1'b0;
    r.rd_len = 5'h00;
    unique case (op)
      EPC_READ: begin
        opc = `EPC_OP_10; // R13
        a = s.addr;
        r.rd_len = `EPC_RD_WORD;
      end
      EPC_UNLOCK: begin
        a = `EPC_ADDR_UNLOCK; // R14
        r.pa = 1'b1;
      end
      EPC_WRITE: begin
        opc = `EPC_OP_01; // R15
        a = s.addr;
        wide = 1'b1;
        r.pa = 1'b1;
        r.poll = 1'b1;
      end
      EPC_FILL: begin
        a = `EPC_ADDR_FILL; // R16
        wide = 1'b1;
        r.pa = 1'b1;
        r.poll = 1'b1;
      end
      EPC_LOCK: begin
        a = `EPC_ADDR_LOCK; // R17
      end
      EPC_GREAD: begin
        opc = `EPC_OP_10; // R2
        r.ps = 1'b1;
        r.rd_len = `EPC_RD_GUARD; // R1
      end
      EPC_ARM: begin
        a = `EPC_ADDR_UNLOCK; // R4
        r.ps = 1'b1;
        r.pa = 1'b1;
      end
      EPC_ERASE: begin
        opc = `EPC_OP_11; // R6
        a = `EPC_ADDR_ERASE;
        r.ps = 1'b1;
        r.pa = 1'b1;
        r.poll = 1'b1;
      end
      EPC_SET: begin
        opc = `EPC_OP_01; // R10
        a = s.addr;
        r.ps = 1'b1;
        r.pa = 1'b1;
        r.poll = 1'b1;
      end
      EPC_FREEZE: begin
        a = `EPC_ADDR_FREEZE; // R12
        r.ps = 1'b1;
        r.pa = 1'b1;
        r.poll = 1'b1;
      end
    endcase
    // A7 is a don't-care only in a word address; fixed fields such as 11xxxxxx need it
    if (op == EPC_READ || op == EPC_WRITE || op == EPC_SET) begin
      a = a & `EPC_A7_MASK; // R18
    end
    r.sh = {1'b1, opc, a, (wide ? s.data : 16'h0000)};
    r.bits = wide ? `EPC_LEN_LONG : `EPC_LEN_SHORT;
    r.rd = 16'h0000;
    r.st = EPC_S_SETUP;
    r.op = op;
    r.cs = 1'b1;
    r.si = 1'b1;
    r.sk = 1'b0;
    r.div = 4'h0;
    r.tmr = 21'h00_0000;
    return r;
  endfunction

  // ----------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------
  always_comb begin
    s_next = s_reg;
    s_next.rsp_v = 1'b0;
    tick = (s_reg.div == SK_HALF_M1);
    s_next.div = tick ? 4'h0 : 4'(s_reg.div + 4'h1);
    unique case (s_reg.st)
      EPC_S_IDLE: begin
        if (cmd_valid) begin
          s_next.req = cmd_op;
          s_next.addr = cmd_addr;
          s_next.data = cmd_data;
          s_next.err = 1'b0;
          if (cmd_op == EPC_SET && !s_reg.erased) begin
            s_next.err = 1'b1; // R11
            s_next.st = EPC_S_DONE;
          end else if (cmd_op == EPC_ERASE || cmd_op == EPC_SET || cmd_op == EPC_FREEZE) begin
            s_next.pend = 1'b1; // R5
            s_next = launch(s_next, EPC_ARM);
          end else begin
            s_next = launch(s_next, cmd_op);
          end
        end
      end
      EPC_S_SETUP: begin
        if (tick) begin
          s_next.sk = 1'b1; // R20
          s_next.st = EPC_S_SHIFT;
        end
      end
      EPC_S_SHIFT: begin
        if (tick) begin
          s_next.sk = !s_reg.sk;
          if (s_reg.sk) begin
            // New data goes out on the falling edge, half a period before sampling
            s_next.sh = {s_reg.sh[25:0], 1'b0};
            s_next.si = s_reg.sh[25];
            s_next.bits = 5'(s_reg.bits - 5'h01);
            if (s_reg.bits == 5'h01) begin
              s_next.si = 1'b0;
              if (s_reg.rd_len != 5'h00) begin
                s_next.st = EPC_S_READ;
                s_next.bits = s_reg.rd_len;
              end else begin
                s_next.st = EPC_S_END;
                s_next.cs = 1'b0; // R21
                s_next.ps = 1'b0; // R7
                s_next.pa = 1'b0;
              end
            end
          end
        end
      end
      EPC_S_READ: begin
        if (tick) begin
          s_next.sk = !s_reg.sk;
          if (s_reg.sk) begin
            // Dummy bit went out before the first read edge, so it is never sampled
            s_next.rd = {s_reg.rd[14:0], so_sync}; // R1
            s_next.bits = 5'(s_reg.bits - 5'h01);
            if (s_reg.bits == 5'h01) begin
              s_next.st = EPC_S_END;
              s_next.cs = 1'b0;
              s_next.ps = 1'b0; // R7
              s_next.pa = 1'b0;
            end
          end
        end
      end
      EPC_S_END: begin
        s_next.tmr = 21'(s_reg.tmr + 21'h00_0001);
        if (s_reg.tmr == CS_LOW_M1) begin
          s_next.tmr = 21'h00_0000;
          if (s_reg.poll && !s_reg.err) begin
            s_next.poll = 1'b0;
            s_next.cs = 1'b1; // R21
            s_next.st = EPC_S_POLL;
          end else begin
            s_next.poll = 1'b0;
            s_next.last_arm = (s_reg.op == EPC_ARM) && !s_reg.err;
            if (s_reg.op == EPC_ERASE && !s_reg.err) begin
              s_next.erased = 1'b1;
            end else if (s_reg.op == EPC_SET || s_reg.op == EPC_FREEZE) begin
              s_next.erased = 1'b0;
            end
            if (s_reg.pend && !s_reg.err) begin
              s_next.pend = 1'b0;
              s_next = launch(s_next, s_reg.req); // R5
            end else begin
              s_next.pend = 1'b0;
              s_next.st = EPC_S_DONE;
            end
          end
        end
      end
      EPC_S_POLL: begin
        s_next.tmr = 21'(s_reg.tmr + 21'h00_0001);
        if (s_reg.tmr >= SV_CYC && so_sync) begin
          s_next.st = EPC_S_END; // R21
          s_next.cs = 1'b0;
          s_next.tmr = 21'h00_0000;
        end else if (s_reg.tmr == WP_M1) begin
          s_next.err = 1'b1;
          s_next.st = EPC_S_END;
          s_next.cs = 1'b0;
          s_next.tmr = 21'h00_0000;
        end
      end
      EPC_S_DONE: begin
        s_next.rsp_v = 1'b1;
        s_next.st = EPC_S_IDLE;
      end
      default: begin
        s_next.st = EPC_S_IDLE;
        s_next.cs = 1'b0;
      end
    endcase
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign cmd_ready = (s_reg.st == EPC_S_IDLE);
  assign rsp_valid = s_reg.rsp_v;
  assign rsp_data = s_reg.rd;
  assign rsp_err = s_reg.err;
  assign chip_select = s_reg.cs;
  assign serial_clock = s_reg.sk;
  assign serial_in = s_reg.si;
  assign protect_select = s_reg.ps;
  assign program_allow = s_reg.pa;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);

  sequence s_sk_high;
    serial_clock [*8];
  endsequence

  sequence s_cs_gap;
    !chip_select [*8];
  endsequence

  AST_SK_HALF_PERIOD: assert property ($rose(serial_clock) |-> s_sk_high ##1 !serial_clock) // R20
    else $error("serial_clock high phase is not eight cycles");
  AST_SK_UNDER_CS: assert property (serial_clock |-> chip_select) // R25
    else $error("serial_clock toggles with chip_select low");
  AST_START_BIT: assert property (s_reg.st == EPC_S_SETUP |-> serial_in && chip_select) // R2
    else $error("frame does not open with a start bit");
  AST_PINS_DROP: assert property ($fell(chip_select) |-> !protect_select && !program_allow) // R7
    else $error("select pins still high after load");
  AST_CS_GAP: assert property ($fell(chip_select) |-> s_cs_gap) // R25
    else $error("chip_select low time too short");
  AST_A7_LOW: assert property (s_reg.st == EPC_S_SETUP // R18
      && (s_reg.op == EPC_READ || s_reg.op == EPC_WRITE || s_reg.op == EPC_SET)
      |-> !s_reg.sh[23])
    else $error("top address bit driven high");
  AST_UNLOCK_FIELD: assert property (s_reg.st == EPC_S_SETUP // R14
      && (s_reg.op == EPC_UNLOCK || s_reg.op == EPC_ARM)
      |-> s_reg.sh[23:22] == 2'h3)
    else $error("unlock or arm frame lacks its fixed address field");
  AST_ARM_FIRST: assert property (s_reg.st == EPC_S_SETUP && $changed(s_reg.op) // R5
      && (s_reg.op == EPC_ERASE || s_reg.op == EPC_SET || s_reg.op == EPC_FREEZE)
      |-> s_reg.last_arm && protect_select && program_allow)
    else $error("guard change not preceded by guard arm");
  AST_ERASE_BEFORE_SET: assert property (s_reg.st == EPC_S_SETUP && s_reg.op == EPC_SET // R11
      |-> s_reg.erased)
    else $error("guard set issued without prior erase");
  AST_READ_ON_ARRAY: assert property (s_reg.st == EPC_S_SETUP && s_reg.op == EPC_READ // R13
      |-> !protect_select && s_reg.sh[26:24] == 3'h6)
    else $error("array read frame wrong");
  AST_POLL_DONE: assert property (s_reg.st == EPC_S_POLL && s_reg.tmr >= SV_CYC && so_sync // R21
      |=> !chip_select && s_reg.st == EPC_S_END)
    else $error("ready status not acted on");
  AST_WRITE_ALLOW: assert property (s_reg.st == EPC_S_SETUP // R15
      && (s_reg.op == EPC_WRITE || s_reg.op == EPC_FILL || s_reg.op == EPC_UNLOCK)
      |-> program_allow && !protect_select)
    else $error("array programming frame lacks program_allow");

endmodule

//--- shared/epc_consts.svh
// Timing counts, opcodes and frame layout for the serial EEPROM host controller
`ifndef EPC_CONSTS_SVH
`define EPC_CONSTS_SVH

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define EPC_CLK_PERIOD_NS 10
`define EPC_SK_PERIOD_NS 160
`define EPC_SK_HALF_CYC ((`EPC_SK_PERIOD_NS / `EPC_CLK_PERIOD_NS) / 2)
`define EPC_CS_LOW_NS 250
`define EPC_CS_LOW_CYC ((`EPC_CS_LOW_NS + `EPC_CLK_PERIOD_NS - 1) / `EPC_CLK_PERIOD_NS)
`define EPC_SV_NS 1000
`define EPC_SV_CYC ((`EPC_SV_NS + `EPC_CLK_PERIOD_NS - 1) / `EPC_CLK_PERIOD_NS)
`define EPC_WP_MS 15
`define EPC_WP_CYC ((`EPC_WP_MS * 1000000) / `EPC_CLK_PERIOD_NS)

// ----------------------------------------------------------------
// Opcodes and fixed address fields
// ----------------------------------------------------------------
`define EPC_OP_10 2'h2
`define EPC_OP_01 2'h1
`define EPC_OP_00 2'h0
`define EPC_OP_11 2'h3
`define EPC_ADDR_UNLOCK 8'hC0
`define EPC_ADDR_FILL 8'h40
`define EPC_ADDR_LOCK 8'h00
`define EPC_ADDR_ERASE 8'hFF
`define EPC_ADDR_FREEZE 8'h00
`define EPC_A7_MASK 8'h7F

// ----------------------------------------------------------------
// Frame lengths
// ----------------------------------------------------------------
`define EPC_LEN_SHORT 5'h0B
`define EPC_LEN_LONG 5'h1B
`define EPC_RD_WORD 5'h10
`define EPC_RD_GUARD 5'h08

`endif

//--- shared/epc_pkg.sv
// Types shared by the serial EEPROM host controller
package epc_pkg;

  typedef enum logic [3:0] {
    EPC_READ = 4'h0,
    EPC_UNLOCK = 4'h1,
    EPC_WRITE = 4'h2,
    EPC_FILL = 4'h3,
    EPC_LOCK = 4'h4,
    EPC_GREAD = 4'h5,
    EPC_ARM = 4'h6,
    EPC_ERASE = 4'h7,
    EPC_SET = 4'h8,
    EPC_FREEZE = 4'h9
  } epc_cmd_t;

  typedef enum logic [2:0] {
    EPC_S_IDLE = 3'h0,
    EPC_S_SETUP = 3'h1,
    EPC_S_SHIFT = 3'h2,
    EPC_S_READ = 3'h3,
    EPC_S_END = 3'h4,
    EPC_S_POLL = 3'h5,
    EPC_S_DONE = 3'h6
  } epc_state_t;

  typedef struct packed {
    epc_state_t st;
    logic [3:0] div;
    logic sk;
    logic cs;
    logic si;
    logic ps;
    logic pa;
    logic [26:0] sh;
    logic [4:0] bits;
    logic [4:0] rd_len;
    logic [15:0] rd;
    logic poll;
    logic pend;
    epc_cmd_t op;
    epc_cmd_t req;
    logic [7:0] addr;
    logic [15:0] data;
    logic [20:0] tmr;
    logic err;
    logic erased;
    logic last_arm;
    logic rsp_v;
  } epc_host_state_t;

endpackage

//--- hw/epc_in_sync.sv
// Three-stage pin synchroniser with agreement filter
`timescale 1ns/1ps
module epc_in_sync #(
  parameter int WIDTH = 1
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // Pins
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);

  typedef struct packed {
    logic [WIDTH-1:0] s1;
    logic [WIDTH-1:0] s2;
    logic [WIDTH-1:0] s3;
    logic [WIDTH-1:0] filt;
  } epc_sync_state_t;

  epc_sync_state_t s_reg;
  epc_sync_state_t s_next;

  // A change is taken only once stages two and three agree
  always_comb begin
    s_next = s_reg;
    s_next.s1 = async_in;
    s_next.s2 = s_reg.s1;
    s_next.s3 = s_reg.s2;
    s_next.filt = (s_reg.s2 & s_reg.s3) | (s_reg.filt & (s_reg.s2 | s_reg.s3));
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  assign sync_out = s_reg.filt;

endmodule

//--- verification/epc_dev_model.sv
// Behavioural model of the protected serial EEPROM seen by the host controller
`timescale 1ns/1ps
module epc_dev_model (
  // Device pins
  input wire logic chip_select,
  input wire logic serial_clock,
  input wire logic serial_in,
  input wire logic protect_select,
  input wire logic program_allow,
  output logic serial_out,
  // Bench control
  input wire logic [31:0] busy_ns
);
  logic [15:0] mem [128];
  logic [15:0] out_sh;
  logic [25:0] sh;
  logic [1:0] op;
  logic [7:0] ad, bound;
  logic started, out_act, bit_q, busy, pre, pe, unlocked, armed, cleared, frozen, was;
  int n, need, out_n, pend;

  initial begin
    foreach (mem[i]) mem[i] = 16'h0;
    unlocked = 1'h0;
    armed = 1'h0;
    cleared = 1'h1;
    frozen = 1'h0;
    bound = 8'hFF;
    busy = 1'h0;
    started = 1'h0;
    out_act = 1'h0;
    bit_q = 1'h0;
    out_n = 0;
    n = 0;
    need = 10;
    pend = 0;
  end

  // Released line shows the inverse of what it would drive with chip_select high
  assign serial_out = chip_select ? (out_act ? bit_q : !busy) : !(out_act ? bit_q : !busy);

  // ----------------------------------------
  // Shifting and decoding
  // ----------------------------------------
  always @(posedge serial_clock) if (chip_select) begin
    if (!started) begin
      started = serial_in;
      n = 0;
    end else if (n < need) begin
      sh = {sh[24:0], serial_in};
      pre = protect_select;
      pe = program_allow;
      n++;
      if (n == 10) begin
        op = sh[9:8];
        ad = sh[7:0];
        if (!pre && (op == 2'h1 || (op == 2'h0 && ad[7:6] == 2'h1))) need = 26;
      end
      if (n == need) begin
        was = armed;
        armed = 1'h0;
        pend = 0;
        case (op)
          2'h2: begin
            out_act = 1'h1;
            bit_q = 1'h0;
            out_sh = pre ? {bound, 8'h00} : mem[ad[6:0]];
            out_n = pre ? 8 : 16;
          end
          2'h0: case (ad[7:6])
            2'h3: if (pe && pre) armed = unlocked; else if (pe) unlocked = 1'h1;
            2'h1: if (pe && unlocked && cleared) pend = 2;
            2'h0: if (pre && pe && was && ad == 8'h00) pend = 5; else if (!pre) unlocked = 1'h0;
            default: ;
          endcase
          2'h1: if (pre && pe && was) pend = 4;
            else if (!pre && pe && unlocked && (cleared || ad[6:0] < bound[6:0])) pend = 1;
          default: if (pre && pe && was && ad[6:0] == 7'h7F) pend = 3;
        endcase
        if (frozen && pend > 2) pend = 0;
      end
    end else if (out_n > 0) begin
      bit_q = out_sh[15];
      out_sh = out_sh << 1;
      out_n--;
    end
  end

  // ----------------------------------------
  // Programming at chip_select fall
  // ----------------------------------------
  always @(negedge chip_select) begin
    started = 1'h0;
    n = 0;
    need = 10;
    out_act = 1'h0;
    case (pend)
      1: mem[ad[6:0]] = sh[15:0];
      2: foreach (mem[i]) mem[i] = sh[15:0];
      3: begin cleared = 1'h1; bound = 8'hFF; end
      4: begin cleared = 1'h0; bound = ad; end
      5: frozen = 1'h1;
      default: ;
    endcase
    if (pend != 0) begin
      busy = 1'h1;
      busy <= #(busy_ns) 1'h0;
    end
    pend = 0;
  end
endmodule

//--- verification/epc_host_bench.sv
// Self-checking bench for the serial EEPROM host controller
`timescale 1ns/1ps
module epc_host_bench import epc_pkg::*; ;
  typedef struct packed {
    epc_cmd_t op;
    logic [7:0] a;
    logic [15:0] d;
    logic [15:0] xd;
    logic xe;
  } epc_row_t;

  logic ref_clk, rst_n, cmd_valid, cmd_ready, rsp_valid, rsp_err, e;
  logic chip_select, serial_clock, serial_in, protect_select, program_allow, serial_out;
  epc_cmd_t cmd_op;
  logic [7:0] cmd_addr;
  logic [15:0] cmd_data, rsp_data, d;
  logic [31:0] busy_ns;
  int err_count, compares;

  epc_row_t rows [34] = '{
    '{EPC_WRITE,8'h05,16'h1234,16'h0,1'h0},
    '{EPC_READ,8'h05,16'h0,16'h0,1'h0},
    '{EPC_UNLOCK,8'hC0,16'h0,16'h0,1'h0},
    '{EPC_WRITE,8'h85,16'hA5A5,16'h0,1'h0},
    '{EPC_READ,8'h05,16'h0,16'hA5A5,1'h0},
    '{EPC_FILL,8'h40,16'h0F0F,16'h0,1'h0},
    '{EPC_READ,8'h7F,16'h0,16'h0F0F,1'h0},
    '{EPC_SET,8'h10,16'h0,16'h0,1'h1},
    '{EPC_ERASE,8'hFF,16'h0,16'h0,1'h0},
    '{EPC_GREAD,8'h00,16'h0,16'h00FF,1'h0},
    '{EPC_WRITE,8'h7F,16'h1111,16'h0,1'h0},
    '{EPC_READ,8'h7F,16'h0,16'h1111,1'h0},
    '{EPC_SET,8'hFF,16'h0,16'h0,1'h0},
    '{EPC_GREAD,8'h00,16'h0,16'h007F,1'h0},
    '{EPC_WRITE,8'h7F,16'h2222,16'h0,1'h0},
    '{EPC_READ,8'h7F,16'h0,16'h1111,1'h0},
    '{EPC_FILL,8'h40,16'h3333,16'h0,1'h0},
    '{EPC_READ,8'h00,16'h0,16'h0F0F,1'h0},
    '{EPC_ERASE,8'hFF,16'h0,16'h0,1'h0},
    '{EPC_SET,8'h10,16'h0,16'h0,1'h0},
    '{EPC_WRITE,8'h10,16'h4444,16'h0,1'h0},
    '{EPC_WRITE,8'h0F,16'h5555,16'h0,1'h0},
    '{EPC_READ,8'h10,16'h0,16'h0F0F,1'h0},
    '{EPC_READ,8'h0F,16'h0,16'h5555,1'h0},
    '{EPC_LOCK,8'h00,16'h0,16'h0,1'h0},
    '{EPC_WRITE,8'h01,16'h7777,16'h0,1'h0},
    '{EPC_READ,8'h01,16'h0,16'h0F0F,1'h0},
    '{EPC_ERASE,8'hFF,16'h0,16'h0,1'h0},
    '{EPC_GREAD,8'h00,16'h0,16'h0010,1'h0},
    '{EPC_UNLOCK,8'hC0,16'h0,16'h0,1'h0},
    '{EPC_ARM,8'hC0,16'h0,16'h0,1'h0},
    '{EPC_FREEZE,8'h00,16'h0,16'h0,1'h0},
    '{EPC_ERASE,8'hFF,16'h0,16'h0,1'h0},
    '{EPC_GREAD,8'h00,16'h0,16'h0010,1'h0}
  };

  epc_host #(.WP_CYCLES(400)) dut (.ref_clk(ref_clk), .rst_n(rst_n), .cmd_valid(cmd_valid),
    .cmd_ready(cmd_ready), .cmd_op(cmd_op), .cmd_addr(cmd_addr), .cmd_data(cmd_data),
    .rsp_valid(rsp_valid), .rsp_data(rsp_data), .rsp_err(rsp_err), .chip_select(chip_select),
    .serial_clock(serial_clock), .serial_in(serial_in), .protect_select(protect_select),
    .program_allow(program_allow), .serial_out(serial_out));
  epc_dev_model dev (.chip_select(chip_select), .serial_clock(serial_clock),
    .serial_in(serial_in), .protect_select(protect_select), .program_allow(program_allow),
    .serial_out(serial_out), .busy_ns(busy_ns));

  // ----------------------------------------
  // Compare, command and closing tasks
  // ----------------------------------------
  task automatic chk1(input string nm, input logic exp, input logic got);
    compares++;
    if (got !== exp) begin
      err_count++;
      $display("CHECK FAILED %s expected %b seen %b", nm, exp, got);
    end
  endtask

  task automatic chk16(input string nm, input logic [15:0] exp, input logic [15:0] got);
    compares++;
    if (got !== exp) begin
      err_count++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic run(input epc_row_t r);
    int k;
    k = 0;
    @(posedge ref_clk);
    cmd_op <= r.op;
    cmd_addr <= r.a;
    cmd_data <= r.d;
    cmd_valid <= 1'h1;
    do begin @(negedge ref_clk); k++; end while (cmd_ready !== 1'h1 && k < 6000);
    @(posedge ref_clk);
    cmd_valid <= 1'h0;
    k = 0;
    while (rsp_valid !== 1'h1 && k < 6000) begin @(negedge ref_clk); k++; end
    chk1("rsp_valid", 1'h1, rsp_valid);
    d = rsp_data;
    e = rsp_err;
  endtask

  task automatic final_report;
    $display("Comparisons %0d mismatches %0d", compares, err_count);
    if (err_count == 0 && compares > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  initial begin
    ref_clk = 1'h0;
    forever #5 ref_clk = ~ref_clk;
  end

  // Select pins must rest low between frames
  always @(negedge ref_clk) if (rst_n === 1'h1 && chip_select === 1'h0)
    chk1("select_pins", 1'h0, protect_select | program_allow);

  initial begin
    repeat (90000) @(posedge ref_clk);
    err_count++;
    final_report;
  end

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    rst_n = 1'h0;
    cmd_valid = 1'h0;
    cmd_op = EPC_READ;
    cmd_addr = 8'h00;
    cmd_data = 16'h0;
    busy_ns = 32'd1500;
    err_count = 0;
    compares = 0;
    repeat (20) @(posedge ref_clk);
    rst_n <= 1'h1;
    foreach (rows[i]) begin
      run(rows[i]);
      chk1("rsp_err", rows[i].xe, e);
      if (rows[i].op == EPC_READ || rows[i].op == EPC_GREAD) chk16("rsp_data", rows[i].xd, d);
    end
    // Reset in mid-frame abandons the partial write
    @(posedge ref_clk);
    cmd_op <= EPC_WRITE;
    cmd_addr <= 8'h0F;
    cmd_data <= 16'h0;
    cmd_valid <= 1'h1;
    @(posedge ref_clk);
    cmd_valid <= 1'h0;
    repeat (100) @(posedge ref_clk);
    rst_n <= 1'h0;
    repeat (20) @(posedge ref_clk);
    chk1("chip_select", 1'h0, chip_select);
    chk1("cmd_ready", 1'h1, cmd_ready);
    rst_n <= 1'h1;
    run(epc_row_t'{EPC_READ, 8'h0F, 16'h0, 16'h0, 1'h0});
    chk16("rsp_data", 16'h5555, d);
    // Slow then overlong programming
    for (int i = 0; i < 2; i++) begin
      busy_ns = i ? 32'd8000 : 32'd3000;
      run(epc_row_t'{EPC_WRITE, 8'h02, 16'h8888, 16'h0, 1'h0});
      chk1("rsp_err", i[0], e);
    end
    final_report;
  end
endmodule
